// *** inc/drolc_pkg.sv ***
package drolc_pkg;

    // ***********************************************************
    // Array shape
    // ***********************************************************
    localparam int NCELL = 10;
    localparam int NFF = 20;
    localparam int ADR_W = 8;

    // ***********************************************************
    // Register offsets (byte addresses, one word each)
    // ***********************************************************
    localparam logic [7:0] ADDR_TTYPE = 8'h00;
    localparam logic [7:0] ADDR_PINCLK = 8'h04;
    localparam logic [7:0] ADDR_POLAR = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_STATE = 8'h10;

    // ***********************************************************
    // Field positions and reset values
    // ***********************************************************
    localparam int CTRL_COMPAT_BIT = 0;
    localparam int CTRL_SECURE_BIT = 1;
    localparam logic [19:0] TTYPE_RST = 20'h00000;
    localparam logic [19:0] PINCLK_RST = 20'h00000;
    localparam logic [9:0] POLAR_RST = 10'h000;
    localparam logic CTRL_COMPAT_RST = 1'b0;
    localparam logic CTRL_SECURE_RST = 1'b0;
    localparam logic [19:0] FF_RST = 20'h00000;

    // ***********************************************************
    // Timing
    // ***********************************************************
    localparam int CLK_MHZ = 50;
    localparam int PWRUP_NS = 1000;
    localparam int PWRUP_CYC = (PWRUP_NS * CLK_MHZ + 999) / 1000;
    localparam int PWRUP_W = 6;

endpackage

// *** logic/drolc_bank.sv ***
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
// What this block does, and what it expects of its controller and software
// R1 - Each flip-flop chooses D or T type.
// R2 - Each flip-flop picks term or pin clock.
// R3 - Two flip-flops per cell, twenty total.
// R4 - Private data, reset, clock term each.
// R5 - All twenty registers feed back internally.
// R6 - Each pin has its own input path.
// R7 - Each pin enabled by own term.
// R8 - Shared synchronous preset sets all high.
// R9 - Controller raises clocks during preset.
// R10 - Each flip-flop has own async reset.
// R11 - Reset clears both stages, nothing pending.
// R12 - Secure bit makes config read all ones.
// R13 - Software sets secure bit last.
// R14 - Compatible mode: D type, term clocks.
// R15 - Power-up clears all registers after delay.
// R16 - Preload loads pin into selected register.
// R17 - T toggles on one, D loads term.
// R18 - Async reset beats preset and loading.
module drolc_bank
    import drolc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [NFF-1:0] sumTerm,
    input wire logic [NFF-1:0] clkTerm,
    input wire logic [NFF-1:0] arstTerm,
    input wire logic clkPin,
    input wire logic syncPreset,
    input wire logic [NCELL-1:0] oeTerm,
    input wire logic preloadMode,
    input wire logic preloadSel,
    input wire logic [NCELL-1:0] pinIn,
    output logic [NCELL-1:0] pinOut,
    output logic [NCELL-1:0] pinOe,
    output logic [NCELL-1:0] pinPath,
    output logic [NFF-1:0] feedback
);

    // ***********************************************************
    // Configuration and state storage
    // ***********************************************************
    logic [19:0] tType_reg;
    logic [19:0] tType_next;

    logic [19:0] pinClk_reg;
    logic [19:0] pinClk_next;

    logic [9:0] polar_reg;
    logic [9:0] polar_next;

    logic compat_reg;
    logic compat_next;

    logic secure_reg;
    logic secure_next;

    logic [NFF-1:0] ffState_reg;
    logic [NFF-1:0] ffState_next;

    logic [NFF-1:0] clkPrev_reg;
    logic [NFF-1:0] clkPrev_next;

    logic [PWRUP_W-1:0] porCnt_reg;
    logic [PWRUP_W-1:0] porCnt_next;

    logic ack_reg;
    logic ack_next;

    logic [31:0] datOut_reg;
    logic [31:0] datOut_next;

    // ***********************************************************
    // Bus decode
    // ***********************************************************
    wire logic reqNew;
    wire logic wrTake;
    wire logic [31:0] wrMask;

    wire logic hitTtype;
    wire logic hitPinclk;
    wire logic hitPolar;
    wire logic hitCtrl;
    wire logic hitState;

    wire logic [31:0] rdTtype;
    wire logic [31:0] rdPinclk;
    wire logic [31:0] rdPolar;
    wire logic [31:0] rdCtrl;
    wire logic [31:0] rdState;
    wire logic [31:0] rdData;

    wire logic wrTtypeEn;
    wire logic wrPinclkEn;
    wire logic wrPolarEn;
    wire logic wrCtrlEn;

    // A request is answered one cycle after it is seen; the write
    // lands on the edge at which the master samples ack.
    assign reqNew = cyc_i & stb_i & ~ack_reg;
    assign wrTake = cyc_i & stb_i & we_i & ack_reg;
    assign wrMask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                     {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign hitTtype = adr_i[7:2] == ADDR_TTYPE[7:2];
    assign hitPinclk = adr_i[7:2] == ADDR_PINCLK[7:2];
    assign hitPolar = adr_i[7:2] == ADDR_POLAR[7:2];
    assign hitCtrl = adr_i[7:2] == ADDR_CTRL[7:2];
    assign hitState = adr_i[7:2] == ADDR_STATE[7:2];

    // ***********************************************************
    // Read path
    // ***********************************************************
    // Only the read path is masked, so a write made after the secure
    // bit is set still changes the stored configuration.
    // R12 secure readback mask
    assign rdTtype = secure_reg ? {12'h000, 20'hFFFFF}
                                : {12'h000, tType_reg};
    assign rdPinclk = secure_reg ? {12'h000, 20'hFFFFF}
                                 : {12'h000, pinClk_reg};
    assign rdPolar = secure_reg ? {22'h000000, 10'h3FF}
                                : {22'h000000, polar_reg};
    assign rdCtrl = secure_reg ? {30'h00000000, 2'h3}
                               : {30'h00000000, secure_reg, compat_reg};
    // R5 state visible to software
    assign rdState = {12'h000, feedback};
    assign rdData = hitTtype ? rdTtype :
                    hitPinclk ? rdPinclk :
                    hitPolar ? rdPolar :
                    hitCtrl ? rdCtrl :
                    hitState ? rdState : 32'h00000000;

    // ***********************************************************
    // Bus answer
    // ***********************************************************
    // Every request is answered, mapped or not, so a master never
    // waits on a stray address.
    assign ack_next = reqNew;
    assign datOut_next = (reqNew & ~we_i) ? rdData : datOut_reg;
    assign ack_o = ack_reg;
    assign dat_o = datOut_reg;

    // ***********************************************************
    // Register writes
    // ***********************************************************
    wire logic [31:0] wrTtypeW;
    wire logic [31:0] wrPinclkW;
    wire logic [31:0] wrPolarW;

    // Lanes whose sel_i bit is low keep their stored bits.
    assign wrTtypeW = ({12'h000, tType_reg} & ~wrMask) | (dat_i & wrMask);
    assign wrPinclkW = ({12'h000, pinClk_reg} & ~wrMask)
                       | (dat_i & wrMask);
    assign wrPolarW = ({22'h000000, polar_reg} & ~wrMask)
                      | (dat_i & wrMask);

    assign wrTtypeEn = wrTake & hitTtype;
    assign wrPinclkEn = wrTake & hitPinclk;
    assign wrPolarEn = wrTake & hitPolar;
    // Both control bits live in byte lane 0.
    assign wrCtrlEn = wrTake & hitCtrl & sel_i[0];

    // R1 per flip-flop type select
    assign tType_next = wrTtypeEn ? wrTtypeW[19:0] : tType_reg;
    // R2 per flip-flop clock select
    assign pinClk_next = wrPinclkEn ? wrPinclkW[19:0] : pinClk_reg;
    assign polar_next = wrPolarEn ? wrPolarW[9:0] : polar_reg;
    // R14 compatible mode select
    assign compat_next = wrCtrlEn ? dat_i[CTRL_COMPAT_BIT] : compat_reg;
    // The secure bit only sets; like a fuse, only reset clears it.
    assign secure_next = secure_reg | (wrCtrlEn & dat_i[CTRL_SECURE_BIT]);

    // ***********************************************************
    // Power-up hold
    // ***********************************************************
    wire logic porBusy;

    // The counter stops at its end value rather than wrapping, so the
    // hold runs once per reset and never returns in normal running.
    // R15 delayed power-up clear
    assign porBusy = porCnt_reg != PWRUP_W'(PWRUP_CYC);
    assign porCnt_next = porBusy ? porCnt_reg + PWRUP_W'(1) : porCnt_reg;

    // ***********************************************************
    // Flip-flop bank
    // ***********************************************************
    // Flip-flop i sits in cell i / 2; the even one drives the pin.
    // R3 twenty flip-flops in ten cells
    for (genvar i = 0; i < NFF; i++) begin : gFf
        wire logic useTog;
        wire logic usePin;
        wire logic clkNow;
        wire logic clkEdge;
        wire logic loadMe;
        wire logic loadVal;
        wire logic preloadVal;
        wire logic edgeVal;
        wire logic blockMe;

        // R14 compatible mode overrides
        assign useTog = tType_reg[i] & ~compat_reg;
        assign usePin = pinClk_reg[i] & ~compat_reg;
        // R2 clock source mux
        assign clkNow = usePin ? clkPin : clkTerm[i];
        // Clocks are sampled, so a clock term must stay high for at
        // least one system clock period or its edge is lost.
        assign clkEdge = clkNow & ~clkPrev_reg[i];
        // Preload leaves the unselected register of the cell as it is.
        // R16 preload register select
        assign loadMe = preloadSel == 1'(i % 2);
        assign preloadVal = loadMe ? pinIn[i / 2] : ffState_reg[i];
        // R17 toggle or load
        assign loadVal = useTog ? ffState_reg[i] ^ sumTerm[i]
                                : sumTerm[i];

        // R11 no edge kept across reset
        assign clkPrev_next[i] = clkNow;

        // R8 preset on active edge
        // R9 preset needs a clock edge
        // R4 private terms per register
        assign edgeVal = preloadMode ? preloadVal :
                         syncPreset ? 1'b1 : loadVal;
        // R18 reset priority first
        // R10 private async reset
        // R15 hold clears during power-up
        assign blockMe = arstTerm[i] | porBusy;
        assign ffState_next[i] = blockMe ? 1'b0 :
                                 clkEdge ? edgeVal : ffState_reg[i];
    end

    // ***********************************************************
    // Pins and feedback
    // ***********************************************************
    // The mask drops the output at once; the stored bit is cleared at
    // the next clock, so nothing is left pending when the term falls.
    // R10 reset masks output at once
    // R5 private feedback paths
    assign feedback = ffState_reg & ~arstTerm;

    // Register 0 of each cell drives the pin; register 1 is buried.
    for (genvar k = 0; k < NCELL; k++) begin : gPin
        assign pinOut[k] = feedback[2 * k] ^ polar_reg[k];
    end

    // R7 per pin enable term
    assign pinOe = oeTerm;
    // R6 dedicated pin input path
    assign pinPath = pinIn;

    // ***********************************************************
    // Clocked storage
    // ***********************************************************
    // Configuration outlives the reset terms; only rst clears it.
    always_ff @(posedge clk) begin
        if (rst) begin
            tType_reg <= TTYPE_RST;
            pinClk_reg <= PINCLK_RST;
            polar_reg <= POLAR_RST;
            compat_reg <= CTRL_COMPAT_RST;
            secure_reg <= CTRL_SECURE_RST;
        end else begin
            tType_reg <= tType_next;
            pinClk_reg <= pinClk_next;
            polar_reg <= polar_next;
            compat_reg <= compat_next;
            secure_reg <= secure_next;
        end
    end

    // The edge history restarts low, so a clock already high at release
    // looks like an edge; the power-up hold swallows it.
    always_ff @(posedge clk) begin
        if (rst) begin
            ffState_reg <= FF_RST;
            clkPrev_reg <= '0;
            porCnt_reg <= '0;
        end else begin
            ffState_reg <= ffState_next;
            clkPrev_reg <= clkPrev_next;
            porCnt_reg <= porCnt_next;
        end
    end

    // Read data is kept until the next read replaces it.
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
            datOut_reg <= 32'h00000000;
        end else begin
            ack_reg <= ack_next;
            datOut_reg <= datOut_next;
        end
    end

endmodule // drolc_bank

// *** testbench/drolc_bank_properties.sv ***
`timescale 1ns/1ns
// ****************************************
// Port-level properties of the bank.
// ****************************************
module drolc_bank_properties
    import drolc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [31:0] dat_o,
    input wire logic [NFF-1:0] clkTerm,
    input wire logic [NFF-1:0] arstTerm,
    input wire logic clkPin,
    input wire logic [NCELL-1:0] oeTerm,
    input wire logic [NCELL-1:0] pinIn,
    input wire logic [NCELL-1:0] pinOe,
    input wire logic [NCELL-1:0] pinPath,
    input wire logic [NFF-1:0] feedback
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered next cycle");
    a_dat_holds: assert property (!ack_o |-> $stable(dat_o))
        else $error("read data changed without ack");
    a_oe_follows: assert property (pinOe == oeTerm)
        else $error("pin enable differs from its term");
    a_pin_path: assert property (pinPath == pinIn)
        else $error("pin input path differs from pin");
    a_arst_masks: assert property ((feedback & arstTerm) == '0)
        else $error("register high while its reset term is high");
    // Two quiet samples cover either reading of the edge-to-state delay.
    a_state_holds: assert property (($stable(clkTerm) &&
        $stable(clkPin) && arstTerm == '0) [*2]
        |=> arstTerm != '0 || $stable(feedback))
        else $error("register changed without an active clock");
    a_powerup_clear: assert property ($fell(rst) |->
        (feedback == '0) [*8])
        else $error("register left low state during power-up hold");
endmodule // drolc_bank_properties

bind drolc_bank drolc_bank_properties props_u (.clk(clk), .rst(rst),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
    .clkTerm(clkTerm), .arstTerm(arstTerm), .clkPin(clkPin),
    .oeTerm(oeTerm), .pinIn(pinIn), .pinOe(pinOe), .pinPath(pinPath),
    .feedback(feedback));

// *** testbench/dual_register_output_logic_cell_tb.sv ***
`timescale 1ns/1ns
module dual_register_output_logic_cell_tb
    import drolc_pkg::*;
;
    logic clk, rst, cyc, stb, we, ack, clkPin, syncPreset;
    logic preloadMode, preloadSel;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, dat, rd;
    logic [NFF-1:0] sumTerm, clkTerm, arstTerm, feedback, e;
    logic [NCELL-1:0] oeTerm, pinIn, pinOut, pinOe, pinPath, pol;
    int nMismatch = 0;
    int samplesChecked = 0;

    drolc_bank dut_u (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat),
        .ack_o(ack), .sumTerm(sumTerm), .clkTerm(clkTerm),
        .arstTerm(arstTerm), .clkPin(clkPin), .syncPreset(syncPreset),
        .oeTerm(oeTerm), .preloadMode(preloadMode),
        .preloadSel(preloadSel), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .pinPath(pinPath), .feedback(feedback));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ****************************************
    // Shared tasks.
    // ****************************************
    task stop_test;
        $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        samplesChecked++;
        if (s !== x) begin
            nMismatch++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask

    // Read data and the write both belong to the edge where ack is seen.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
        if (ack !== 1'b1) begin
            nMismatch++;
            stop_test;
        end
        rd = dat;
        {cyc, stb} <= 2'b00;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] x, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, x);
    endtask

    // Three spare edges let either edge-to-state delay settle.
    task pulse(input logic [NFF-1:0] m, input logic p);
        @(posedge clk);
        {clkTerm, clkPin} <= {m, p};
        @(posedge clk);
        {clkTerm, clkPin} <= '0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        {rst, cyc, stb, we, adr, sel, wdat} <= {4'h8, 8'h00, 4'hF, 32'h0};
        {sumTerm, clkTerm, arstTerm, clkPin, syncPreset} <= '0;
        {preloadMode, preloadSel, oeTerm, pinIn} <= {2'b00, 10'h35A, 10'h2C5};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_chk(ADDR_TTYPE, {12'h000, TTYPE_RST}, "ttype_rst");
        rd_chk(8'h14, 32'h0, "unmapped");
        chk("oe_term", pinOe, 32'h35A);
        chk("pin_path", pinPath, 32'h2C5);
        sumTerm <= '1;
        pulse('1, 1'b1);
        chk("powerup", feedback, 32'h0);
        repeat (PWRUP_CYC) @(posedge clk);
        bus(1'b1, ADDR_TTYPE, 32'h000AAAAA);
        pulse('1, 1'b0);
        chk("d_t_load", feedback, 32'h000FFFFF);
        pulse('1, 1'b0);
        chk("toggle", feedback, 32'h00055555);
        bus(1'b1, ADDR_CTRL, 32'h1);
        sumTerm <= '0;
        pulse('1, 1'b1);
        chk("compat", feedback, 32'h0);
        bus(1'b1, ADDR_CTRL, 32'h0);
        bus(1'b1, ADDR_PINCLK, 32'h3);
        sumTerm <= '1;
        pulse('0, 1'b1);
        chk("pin_clk", feedback, 32'h3);
        sumTerm <= '0;
        pulse('1, 1'b0);
        rd_chk(ADDR_STATE, 32'h3, "term_clk");
        syncPreset <= 1'b1;
        pulse('1, 1'b1);
        chk("preset", feedback, 32'h000FFFFF);
        arstTerm <= 20'h0000F;
        pulse('1, 1'b1);
        chk("arst_wins", feedback, 32'h000FFFF0);
        {arstTerm, syncPreset} <= '0;
        repeat (2) @(posedge clk);
        #1;
        chk("no_pending", feedback, 32'h000FFFF0);
        preloadMode <= 1'b1;
        e = 20'hFFFF0;
        for (int s = 1; s >= 0; s--) begin
            preloadSel <= s[0];
            pulse('1, 1'b1);
            for (int k = 0; k < NCELL; k++) e[2*k+s] = pinIn[k];
            chk("preload", feedback, e);
        end
        preloadMode <= 1'b0;
        bus(1'b1, ADDR_POLAR, 32'h00F);
        oeTerm <= 10'h0A5;
        @(posedge clk);
        #1;
        chk("oe_swap", pinOe, 32'h0A5);
        pol = 10'h00F;
        for (int k = 0; k < NCELL; k++) pol[k] = pol[k] ^ e[2*k];
        chk("polarity", pinOut, pol);
        bus(1'b1, ADDR_CTRL, 32'h2);
        rd_chk(ADDR_TTYPE, 32'h000FFFFF, "sec_ttype");
        rd_chk(ADDR_POLAR, 32'h3FF, "sec_polar");
        rd_chk(ADDR_CTRL, 32'h3, "sec_ctrl");
        rd_chk(ADDR_STATE, {12'h000, e}, "state");
        stop_test;
    end
endmodule // dual_register_output_logic_cell_tb
